// ### verilog/memmap_pkg.sv
// package: memory map constants and bus carrier types for the address decoder
package memmap_pkg;
    // bus carrier from the core
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // region enumeration
    typedef enum logic [3:0] {
        REG_ZERO_PAGE,
        REG_RAM,
        REG_HIGH_IO,
        REG_RESERVED,
        REG_UNIMPL,
        REG_MONITOR_ROM,
        REG_BURN_ROM,
        REG_FLASH_PROTECT,
        REG_USER_FLASH,
        REG_VECTORS
    } region_t;

    // region bounds
    localparam logic [15:0] ZP_LO        = 16'h0000;
    localparam logic [15:0] ZP_HI        = 16'h003F;
    localparam logic [15:0] RAM_LO       = 16'h0040;
    localparam logic [15:0] RAM_HI       = 16'h01BF;
    localparam logic [15:0] FLASH_LO     = 16'hE000;
    localparam logic [15:0] FLASH_HI     = 16'hFDFF;
    localparam logic [15:0] BURN_LO      = 16'h1C00;
    localparam logic [15:0] BURN_HI      = 16'h1E1F;
    localparam logic [15:0] HIO_LO       = 16'hFE00;
    localparam logic [15:0] HIO_HI       = 16'hFE0C;
    localparam logic [15:0] HIO_RSV_A    = 16'hFE02;
    localparam logic [15:0] HIO_RSV_B    = 16'hFE07;
    localparam logic [15:0] HRSV_LO      = 16'hFE0D;
    localparam logic [15:0] HRSV_HI      = 16'hFE0F;
    localparam logic [15:0] COMPAT_LO    = 16'hFE10;
    localparam logic [15:0] COMPAT_HI    = 16'hFE1F;
    localparam logic [15:0] MON_LO       = 16'hFE20;
    localparam logic [15:0] MON_HI       = 16'hFF55;
    localparam logic [15:0] FLBP_ADDR    = 16'hFF7E;
    localparam logic [15:0] VEC_LO       = 16'hFFDC;
    localparam logic [15:0] VEC_HI       = 16'hFFFF;
    localparam logic [15:0] SEC_LO       = 16'hFFF6;
    localparam logic [15:0] SEC_HI       = 16'hFFFD;
    localparam logic [15:0] WDOG_ADDR    = 16'hFFFF;

    // zero-page register offsets
    localparam logic [15:0] FIRST_DATA_ADDR   = 16'h0000;
    localparam logic [15:0] SECOND_DATA_ADDR  = 16'h0001;
    localparam logic [15:0] THIRD_DATA_ADDR   = 16'h0002;
    localparam logic [15:0] FOURTH_DATA_ADDR  = 16'h0003;
    localparam logic [15:0] FIRST_DIR_ADDR    = 16'h0004;
    localparam logic [15:0] SECOND_DIR_ADDR   = 16'h0005;
    localparam logic [15:0] THIRD_DIR_ADDR    = 16'h0006;
    localparam logic [15:0] FOURTH_DIR_ADDR   = 16'h0007;
    localparam logic [15:0] FIFTH_DATA_ADDR   = 16'h0008;
    localparam logic [15:0] ZRSV_LO           = 16'h0009;
    localparam logic [15:0] ZRSV_HI           = 16'h000B;
    localparam logic [15:0] FIFTH_DIR_ADDR    = 16'h000C;
    // interrupt registers placed in free zero-page space
    localparam logic [15:0] IRQ_STATUS_ADDR   = 16'h003E;
    localparam logic [15:0] IRQ_MASK_ADDR     = 16'h003F;

    // implemented bit masks per port
    localparam logic [7:0] FIRST_MASK   = 8'h0F;
    localparam logic [7:0] SECOND_MASK  = 8'h3F;
    localparam logic [7:0] THIRD_MASK   = 8'h03;
    localparam logic [7:0] FOURTH_MASK  = 8'h7F;
    localparam logic [7:0] FIFTH_MASK   = 8'h03;
    localparam logic [7:0] DIR_RESET    = 8'h00;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    // interrupt status bits
    localparam int IRQ_ILLEGAL_BIT = 0;
    localparam int IRQ_WDOG_BIT    = 1;
    localparam logic [7:0] IRQ_MASK_IMPL = 8'h03;
endpackage

// ### verilog/memory_map_address_decode.sv
// memory map address decoder with port registers and illegal-access event
// Function
// R01: sixteen-bit address, each to one region
// R02: unimplemented access raises illegal-address indication
// R03: reserved accesses need no defined result
// R04: most registers decode in zero page
// R05: high-page registers at FE00-FE0C, FF7E
// R06: user flash, ram and burn-in rom
// R07: monitor rom from FE20 to FF55
// R08: vectors FFDC-FFFF, security bytes inside
// R09: FFFF reads vector, writes watchdog control
// R10: FE10-FE1F treated as unimplemented
// R11: first port data four bits, no reset
// R12: fourth port seven bits, second six
// R13: direction registers masked, cleared on reset
// R14: 0009-000B reserved, read zero
//
// The plain strobed port was decided locally.
module memory_map_address_decode
    import memmap_pkg::*;
(
    input  wire logic     sys_clk_i,       // bus clock
    input  wire logic     nrst_i,          // async reset, active low
    input  wire bus_req_t bus_i,           // core request
    input  wire logic [7:0] ext_rdata_i,   // data from selected memory/peripheral
    output logic [7:0]    rdata_o,         // read data, cycle after strobe
    output region_t       region_o,        // decoded region of bus address
    output logic          illegal_addr_o,  // pulse: unimplemented access
    output logic          secure_byte_o,   // address hits a security byte
    output logic          wdog_write_o,    // pulse: watchdog control write
    output logic [7:0]    wdog_data_o,     // data of last watchdog write
    output logic          ext_sel_o,       // access goes outside this block
    output logic [4:0][7:0] port_data_o,   // port output latches
    output logic [4:0][7:0] port_dir_o,    // port direction bits
    output logic          irq_o            // level interrupt
);
    import memmap_pkg::*;

    // =========================================================
    // address decode
    // =========================================================
    wire logic [15:0] a = bus_i.addr;
    wire logic acc = bus_i.wr | bus_i.rd;  // any access this cycle
    // R04 zero page window
    wire logic in_zp    = (a <= ZP_HI);
    // R06 ram, burn rom, user flash
    wire logic in_ram   = (a >= RAM_LO) && (a <= RAM_HI);
    wire logic in_burn  = (a >= BURN_LO) && (a <= BURN_HI);
    wire logic in_flash = (a >= FLASH_LO) && (a <= FLASH_HI);
    // R05 high-page single registers, two reserved holes
    wire logic in_hio   = (a >= HIO_LO) && (a <= HIO_HI)
                          && (a != HIO_RSV_A) && (a != HIO_RSV_B);
    wire logic in_hrsv  = (a == HIO_RSV_A) || (a == HIO_RSV_B)
                          || ((a >= HRSV_LO) && (a <= HRSV_HI));
    // R07 monitor rom
    wire logic in_mon   = (a >= MON_LO) && (a <= MON_HI);
    wire logic in_flbp  = (a == FLBP_ADDR);
    // R08 vectors and security bytes
    wire logic in_vec   = (a >= VEC_LO);
    wire logic in_sec   = (a >= SEC_LO) && (a <= SEC_HI);
    // R14 reserved zero-page bytes
    wire logic in_zrsv  = (a >= ZRSV_LO) && (a <= ZRSV_HI);

    // R01 priority chain gives exactly one region; R10 holes fall through
    region_t region;
    always_comb begin
        if (in_zp)
            region = in_zrsv ? REG_RESERVED : REG_ZERO_PAGE;
        else if (in_ram)   region = REG_RAM;
        else if (in_burn)  region = REG_BURN_ROM;
        else if (in_flash) region = REG_USER_FLASH;
        else if (in_hio)   region = REG_HIGH_IO;
        else if (in_hrsv)  region = REG_RESERVED;
        else if (in_mon)   region = REG_MONITOR_ROM;
        else if (in_flbp)  region = REG_FLASH_PROTECT;
        else if (in_vec)   region = REG_VECTORS;
        else               region = REG_UNIMPL;
    end
    assign region_o      = region;
    assign secure_byte_o = in_sec;

    // =========================================================
    // local register selects
    // =========================================================
    wire logic local_sel = (region == REG_ZERO_PAGE)
                           || (region == REG_RESERVED && in_zp);
    // R09 write at top address is watchdog, read is vector
    wire logic wdog_hit  = bus_i.wr && (a == WDOG_ADDR);
    // R03 reserved high-page and unimplemented bytes go nowhere; outside fabric gets rest
    assign ext_sel_o = acc && !local_sel && !wdog_hit
                       && (region != REG_UNIMPL)
                       && (region != REG_RESERVED);

    // =========================================================
    // port registers
    // =========================================================
    logic [4:0][7:0] data_r;   // port latches, not reset
    logic [4:0][7:0] dir_r;    // direction bits
    logic [4:0][7:0] impl;     // implemented bits per port
    assign impl[0] = FIRST_MASK;
    assign impl[1] = SECOND_MASK;
    assign impl[2] = THIRD_MASK;
    assign impl[3] = FOURTH_MASK;
    assign impl[4] = FIFTH_MASK;

    // address of each data and direction register
    logic [4:0][15:0] dat_addr;
    logic [4:0][15:0] dir_addr;
    assign dat_addr[0] = FIRST_DATA_ADDR;
    assign dat_addr[1] = SECOND_DATA_ADDR;
    assign dat_addr[2] = THIRD_DATA_ADDR;
    assign dat_addr[3] = FOURTH_DATA_ADDR;
    assign dat_addr[4] = FIFTH_DATA_ADDR;
    assign dir_addr[0] = FIRST_DIR_ADDR;
    assign dir_addr[1] = SECOND_DIR_ADDR;
    assign dir_addr[2] = THIRD_DIR_ADDR;
    assign dir_addr[3] = FOURTH_DIR_ADDR;
    assign dir_addr[4] = FIFTH_DIR_ADDR;

    // per-register write strobes, decoded once as wires
    localparam int N_PORTS = 5; // ports decoded by this block
    logic [4:0] dat_wr;        // data latch write this cycle
    logic [4:0] dir_wr;        // direction write this cycle
    genvar gi;
    generate
        for (gi = 0; gi < N_PORTS; gi++) begin : g_port
            assign dat_wr[gi] = bus_i.wr && (a == dat_addr[gi]);
            assign dir_wr[gi] = bus_i.wr && (a == dir_addr[gi]);
        end
    endgenerate

    // data latches have no reset: contents survive a reset
    // one process for all latches so no vector has two writers
    // R11 R12 data latches keep value over reset
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < N_PORTS; i++) begin
            if (dat_wr[i])
                data_r[i] <= bus_i.wdata & impl[i];
        end
    end
    // R13 direction bits masked and cleared
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            dir_r <= {5{DIR_RESET}};
        else begin
            for (int i = 0; i < N_PORTS; i++) begin
                if (dir_wr[i])
                    dir_r[i] <= bus_i.wdata & impl[i];
            end
        end
    end
    assign port_data_o = data_r;
    assign port_dir_o  = dir_r;

    // =========================================================
    // watchdog write capture
    // =========================================================
    logic       wdog_pulse_r;  // one cycle after write
    logic [7:0] wdog_data_r;   // last written value
    // R09 write path to watchdog control
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wdog_pulse_r <= 1'b0;
            wdog_data_r  <= ZERO_BYTE;
        end else begin
            wdog_pulse_r <= wdog_hit;
            if (wdog_hit)
                wdog_data_r <= bus_i.wdata;
        end
    end
    assign wdog_write_o = wdog_pulse_r;
    assign wdog_data_o  = wdog_data_r;

    // =========================================================
    // illegal access and interrupt registers
    // =========================================================
    // R02 R10 unimplemented access is the illegal event source
    wire logic illegal_now = acc && (region == REG_UNIMPL);
    logic       illegal_r;     // registered pulse
    logic [7:0] irq_stat_r;    // sticky events, write one to clear
    logic [7:0] irq_mask_r;    // enable per event
    logic [7:0] ev;            // events seen this cycle
    // event bits placed by their named positions
    always_comb begin
        ev                  = ZERO_BYTE;
        ev[IRQ_ILLEGAL_BIT] = illegal_now;
        ev[IRQ_WDOG_BIT]    = wdog_hit;
    end
    wire logic stat_wr = bus_i.wr && a == IRQ_STATUS_ADDR;
    wire logic mask_wr = bus_i.wr && a == IRQ_MASK_ADDR;
    // set beats clear in the same cycle
    wire logic [7:0] stat_nxt =
        ((irq_stat_r & ~(stat_wr ? bus_i.wdata : ZERO_BYTE)) | ev)
        & IRQ_MASK_IMPL;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            illegal_r  <= 1'b0;
            irq_stat_r <= ZERO_BYTE;
            irq_mask_r <= ZERO_BYTE;
        end else begin
            illegal_r  <= illegal_now;
            irq_stat_r <= stat_nxt;
            if (mask_wr)
                irq_mask_r <= bus_i.wdata & IRQ_MASK_IMPL;
        end
    end
    assign illegal_addr_o = illegal_r;
    assign irq_o = |(irq_stat_r & irq_mask_r);

    // =========================================================
    // read data mux, registered
    // =========================================================
    logic [7:0] loc_rd;        // local register read value
    always_comb begin
        loc_rd = ZERO_BYTE;    // R14 reserved and unused read zero
        for (int i = 0; i < 5; i++) begin
            if (a == dat_addr[i]) loc_rd = data_r[i];
            if (a == dir_addr[i]) loc_rd = dir_r[i];
        end
        if (a == IRQ_STATUS_ADDR) loc_rd = irq_stat_r;
        if (a == IRQ_MASK_ADDR)   loc_rd = irq_mask_r;
    end
    logic       rd_loc_r;      // read was local
    logic       rd_ext_r;      // read went outside
    logic [7:0] loc_rd_r;      // captured local value
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_loc_r <= 1'b0;
            rd_ext_r <= 1'b0;
            loc_rd_r <= ZERO_BYTE;
        end else begin
            rd_loc_r <= bus_i.rd && local_sel;
            rd_ext_r <= bus_i.rd && ext_sel_o;
            loc_rd_r <= loc_rd;
        end
    end
    // R03 unimplemented and reserved reads return zero here
    assign rdata_o = rd_loc_r ? loc_rd_r :
                     rd_ext_r ? ext_rdata_i : ZERO_BYTE;

    // =========================================================
    // assertions
    // =========================================================
    // R10 compat hole flags illegal
    AST_ILLEGAL: assert property ( // R10
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (acc && a >= COMPAT_LO && a <= COMPAT_HI) |=> illegal_addr_o)
        else $error("compat hole did not flag illegal");
    // R07 monitor rom window
    AST_MON: assert property ( // R07
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (a >= MON_LO && a <= MON_HI) |-> region_o == REG_MONITOR_ROM)
        else $error("monitor rom not selected");
    // R09 watchdog write path
    AST_WDOG: assert property ( // R09
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (bus_i.wr && a == WDOG_ADDR) |=> wdog_write_o
        && wdog_data_o == $past(bus_i.wdata))
        else $error("watchdog write lost");
    // R09 top byte read goes out
    AST_VECRD: assert property ( // R09
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (bus_i.rd && a == WDOG_ADDR) |-> ext_sel_o && !wdog_hit)
        else $error("vector read misrouted");
    // R13 unimplemented direction bits
    AST_DIR: assert property ( // R13
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (port_dir_o[0] & ~FIRST_MASK) == ZERO_BYTE
        && (port_dir_o[3] & ~FOURTH_MASK) == ZERO_BYTE)
        else $error("unimplemented direction bit set");
    // R14 reserved bytes read zero
    AST_RSV: assert property ( // R14
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (bus_i.rd && a >= ZRSV_LO && a <= ZRSV_HI) |=> rdata_o == ZERO_BYTE)
        else $error("reserved byte read nonzero");
    // R12 fourth port top bit
    AST_DATA: assert property ( // R12
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (bus_i.rd && a == FOURTH_DATA_ADDR) |=> rdata_o[7] == 1'b0)
        else $error("fourth port bit 7 nonzero");
    // R05 high page holes
    AST_HIO: assert property ( // R05
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (a == HIO_RSV_A || a == HIO_RSV_B) |-> region_o == REG_RESERVED)
        else $error("high page reserved hole decoded");
    // R11 first port upper nibble
    AST_FIRST: assert property ( // R11
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (bus_i.rd && a == FIRST_DATA_ADDR) |=> rdata_o[7:4] == 4'h0)
        else $error("first port upper bits nonzero");
    // R02 illegal event recorded
    AST_STAT: assert property ( // R02
        @(posedge sys_clk_i) disable iff (!nrst_i)
        illegal_now |=> irq_stat_r[IRQ_ILLEGAL_BIT])
        else $error("illegal event not recorded");
    // R08 security bytes inside vectors
    AST_SEC: assert property ( // R08
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (a >= SEC_LO && a <= SEC_HI) |-> secure_byte_o
        && region_o == REG_VECTORS)
        else $error("security byte not flagged");
endmodule

// ### tb/core_model.sv
// processor core model issuing byte reads and writes to the decoder
module core_model (
    input  wire logic          sys_clk_i, // bus clock
    output memmap_pkg::bus_req_t bus_o    // request to the decoder
);
    timeunit 1ns;
    timeprecision 1ps;
    import memmap_pkg::*;

    // ==========================================================
    // request driver
    // bus starts idle so nothing is taken during reset
    initial begin
        bus_o = '0;
    end

    // one request held over exactly one rising edge; the next call
    // replaces it at that same edge, so back-to-back needs no gap
    // core never relies on reserved results
    task automatic issue(input logic [15:0] a, input logic [7:0] d,
                         input logic w, input logic r);
        bus_o <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge sys_clk_i);
    endtask
endmodule

// ### tb/test_memory_map_address_decode.sv
// testbench: decoder regions, port registers, events and interrupt
module test_memory_map_address_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import memmap_pkg::*;

    // ==========================================================
    // signals
    typedef struct packed {
        logic       ext; // answer comes from outside memory
        logic [7:0] d;   // expected read byte
        logic       ill; // illegal pulse expected
        logic       wdg; // watchdog pulse expected
    } note_t;
    logic                 sys_clk;             // bus clock
    logic                 nrst;                // reset, active low
    bus_req_t             bus;                 // core request
    logic [7:0]           ext_rdata;           // outside memory byte
    logic [7:0]           rdata;               // read answer
    region_t              region;              // decoded region
    logic                 illegal, secure;     // event and security hit
    logic                 wdog_wr, ext_sel;    // watchdog pulse, routing
    logic [7:0]           wdog_data;           // last watchdog byte
    logic [4:0][7:0]      port_data, port_dir; // port latches, direction bits
    logic                 irq;                 // level interrupt
    note_t                q[$];                // pending expectations
    note_t                cur;                 // note being compared
    int                   n_fail = 0;          // mismatches
    int                   n_compared = 0;      // comparisons
    logic                 acc_d, rd_d, chk_rgn; // answer cycle flags, region check enable
    logic [31:0]          seed;                // random state
    region_t              exp_rgn;             // expected region
    logic                 exp_sec, exp_ext;    // expected side flags
    logic [7:0]           v;                   // scratch byte
    logic [7:0]  mk [10] = '{8'h0F, 8'h3F, 8'h03, 8'h7F, 8'h0F,
                             8'h3F, 8'h03, 8'h7F, 8'h03, 8'h03};
    logic [15:0] ta [32] = '{16'h0010, 16'h0040, 16'h01BF, 16'h01C0,
        16'h1BFF, 16'h1C00, 16'h1E1F, 16'h1E20, 16'hDFFF, 16'hE000,
        16'hFDFF, 16'hFE00, 16'hFE0C, 16'hFE02, 16'hFE07, 16'hFE0D,
        16'hFE0F, 16'hFE10, 16'hFE1F, 16'hFE20, 16'hFF55, 16'hFF56,
        16'hFF7D, 16'hFF7E, 16'hFF7F, 16'hFFDB, 16'hFFDC, 16'hFFF5,
        16'hFFF6, 16'hFFFD, 16'hFFFE, 16'hFFFF};
    region_t     tr [32] = '{REG_ZERO_PAGE, REG_RAM, REG_RAM, REG_UNIMPL,
        REG_UNIMPL, REG_BURN_ROM, REG_BURN_ROM, REG_UNIMPL, REG_UNIMPL,
        REG_USER_FLASH, REG_USER_FLASH, REG_HIGH_IO, REG_HIGH_IO,
        REG_RESERVED, REG_RESERVED, REG_RESERVED, REG_RESERVED,
        REG_UNIMPL, REG_UNIMPL, REG_MONITOR_ROM, REG_MONITOR_ROM,
        REG_UNIMPL, REG_UNIMPL, REG_FLASH_PROTECT, REG_UNIMPL, REG_UNIMPL,
        REG_VECTORS, REG_VECTORS, REG_VECTORS, REG_VECTORS, REG_VECTORS,
        REG_VECTORS};

    // ==========================================================
    // instances
    core_model core_model_i (.sys_clk_i(sys_clk), .bus_o(bus));
    memory_map_address_decode memory_map_address_decode_i (
        .sys_clk_i(sys_clk), .nrst_i(nrst), .bus_i(bus),
        .ext_rdata_i(ext_rdata), .rdata_o(rdata), .region_o(region),
        .illegal_addr_o(illegal), .secure_byte_o(secure),
        .wdog_write_o(wdog_wr), .wdog_data_o(wdog_data),
        .ext_sel_o(ext_sel), .port_data_o(port_data),
        .port_dir_o(port_dir), .irq_o(irq));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // note the expectation, then hand the access to the core model
    task automatic acc(input logic [15:0] a, input logic [7:0] d,
        input logic w, input logic [7:0] e, input logic x,
        input logic il, input logic wd);
        q.push_back('{x, e, il, wd});
        core_model_i.issue(a, d, w, !w);
    endtask

    // one idle cycle, then stop mid-cycle where levels have settled
    task automatic idle_neg;
        core_model_i.issue(16'h0000, 8'h00, 1'b0, 1'b0);
        @(negedge sys_clk);
    endtask

    task automatic lvl(input logic e);
        idle_neg;
        check({7'h00, irq}, {7'h00, e});
        @(posedge sys_clk);
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // clock, outside memory data and answer-cycle flags
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // random outside data changes every cycle so a stale byte shows
    always @(posedge sys_clk) begin
        seed      <= lfsr(seed);
        ext_rdata <= seed[7:0];
        acc_d     <= bus.wr | bus.rd;
        rd_d      <= bus.rd;
    end

    // ==========================================================
    // monitor: oldest note against the answer cycle
    always @(negedge sys_clk) begin
        if (acc_d) begin
            cur = q.pop_front();
            check({7'h00, illegal}, {7'h00, cur.ill});
            check({7'h00, wdog_wr}, {7'h00, cur.wdg});
            if (rd_d) check(rdata, cur.ext ? ext_rdata : cur.d);
        end else begin
            check({6'h00, illegal, wdog_wr}, 8'h00);
        end
        if (chk_rgn && bus.rd) begin
            check({4'h0, region}, {4'h0, exp_rgn});
            check({6'h00, secure, ext_sel}, {6'h00, exp_sec, exp_ext});
        end
    end

    // ==========================================================
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("ERROR at %0t: run timed out", $time);
        test_done;
    end

    // ==========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        ext_rdata = 8'h00;
        seed = 32'hEFD2EDF5;
        {acc_d, rd_d, chk_rgn} = 3'b000;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        for (int i = 0; i < 5; i++) check(port_dir[i], 8'h00);
        @(posedge sys_clk);
        $display("test reset values done");
        // random bytes then all ones, read back at once
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 10; i++) begin
                v = p ? 8'hFF : seed[15:8];
                acc((i < 9) ? 16'(i) : 16'h000C, v, 1'b1, 8'h00, 0, 0, 0);
                acc((i < 9) ? 16'(i) : 16'h000C, 8'h00, 1'b0, v & mk[i],
                    0, 0, 0);
            end
        end
        // latch and direction outputs after the all-ones pass
        idle_neg;
        for (int i = 0; i < 5; i++) begin
            check(port_data[i], mk[(i < 4) ? i : 8]);
            check(port_dir[i], mk[(i < 4) ? i + 4 : 9]);
        end
        @(posedge sys_clk);
        for (int a = 9; a < 12; a++) begin
            acc(16'(a), 8'hFF, 1'b1, 8'h00, 0, 0, 0);
            acc(16'(a), 8'h00, 1'b0, 8'h00, 0, 0, 0);
        end
        $display("test port registers done");
        // data survives a second reset, direction does not
        acc(16'h0000, 8'h0A, 1'b1, 8'h00, 0, 0, 0);
        acc(16'h0004, 8'h0F, 1'b1, 8'h00, 0, 0, 0);
        idle_neg;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        acc(16'h0000, 8'h00, 1'b0, 8'h0A, 0, 0, 0);
        acc(16'h0004, 8'h00, 1'b0, 8'h00, 0, 0, 0);
        $display("test mid-run reset done");
        // every region edge outside zero page plus one zero-page byte, back to back reads
        for (int i = 0; i < 32; i++) begin
            exp_rgn = tr[i];
            exp_sec = ta[i] inside {[16'hFFF6:16'hFFFD]};
            exp_ext = !(tr[i] inside {REG_ZERO_PAGE, REG_RESERVED,
                                      REG_UNIMPL});
            chk_rgn = 1'b1;
            acc(ta[i], 8'h00, 1'b0, 8'h00, exp_ext, tr[i] == REG_UNIMPL,
                0);
        end
        chk_rgn = 1'b0;
        acc(16'hFF60, 8'h55, 1'b1, 8'h00, 0, 1, 0);
        $display("test region map done");
        // top byte: write reaches watchdog, read is the vector
        v = seed[15:8];
        acc(16'hFFFF, v, 1'b1, 8'h00, 0, 0, 1);
        idle_neg;
        check(wdog_data, v);
        @(posedge sys_clk);
        acc(16'hFFFF, 8'h00, 1'b0, 8'h00, 1, 0, 0);
        $display("test watchdog address done");
        // sticky status, mask and level output
        acc(16'h003F, 8'h00, 1'b1, 8'h00, 0, 0, 0);
        acc(16'h003E, 8'h03, 1'b1, 8'h00, 0, 0, 0);
        acc(16'h003E, 8'h00, 1'b0, 8'h00, 0, 0, 0);
        acc(16'hFE10, 8'h00, 1'b0, 8'h00, 0, 1, 0);
        acc(16'h003E, 8'h00, 1'b0, 8'h01, 0, 0, 0);
        lvl(1'b0);
        acc(16'h003F, 8'h01, 1'b1, 8'h00, 0, 0, 0);
        lvl(1'b1);
        acc(16'h003F, 8'h02, 1'b1, 8'h00, 0, 0, 0);
        lvl(1'b0);
        acc(16'hFFFF, 8'h00, 1'b1, 8'h00, 0, 0, 1);
        lvl(1'b1);
        acc(16'h003E, 8'h03, 1'b1, 8'h00, 0, 0, 0);
        lvl(1'b0);
        acc(16'h003F, 8'h00, 1'b0, 8'h02, 0, 0, 0);
        acc(16'h003E, 8'h00, 1'b0, 8'h00, 0, 0, 0);
        idle_neg;
        @(posedge sys_clk);
        check(8'(q.size()), 8'h00);
        $display("test interrupt done");
        test_done;
    end
endmodule
